// [ecp_parallel_port_registers_tb.sv]
`timescale 1ns/1ns
`default_nettype none
`include "epr_consts.svh"
// ************
// Bench
// ************
module ecp_parallel_port_registers_tb;
  logic CLK_IN = 0, RESET_N_IN = 0, AEN_IN = 0, WR_IN = 0, RD_IN = 0, ack_req = 0;
  logic [15:0] ADDR_IN = 16'h0000;
  logic [7:0] WDATA_IN = 8'h00, pbyte = 8'hA5, RDATA_OUT, PD_IN, PD_OUT, m_data, last, c;
  logic [3:0] lv = 4'h1;
  logic PD_OE_N_OUT, FAULT_N_IN, SELECT_IN, PAPER_ERROR_IN, ACK_N_IN, BUSY_IN;
  logic STROBE_N_OUT, AUTOFEED_N_OUT, INIT_N_OUT, SEL_IN_N_OUT, ACK_IRQ_OUT;
  logic [5:0] m_ctrl = 6'h00;
  logic [2:0] m_mode = 3'h0;
  logic m_srv = 1'b1;
  logic epp_en = 1'b0;
  logic [7:0] q[$];
  int n_fail = 0, comparisons = 0, k;
  localparam logic [15:0] BASE = 16'h0378;

  epr_port u_epr_port (.CLK_IN(CLK_IN), .RESET_N_IN(RESET_N_IN), .BASE_ADDR_IN(BASE),
    .ADDR_IN(ADDR_IN), .AEN_IN(AEN_IN), .WR_IN(WR_IN), .RD_IN(RD_IN), .WDATA_IN(WDATA_IN),
    .RDATA_OUT(RDATA_OUT), .PD_IN(PD_IN), .PD_OUT(PD_OUT), .PD_OE_N_OUT(PD_OE_N_OUT),
    .FAULT_N_IN(FAULT_N_IN), .SELECT_IN(SELECT_IN), .PAPER_ERROR_IN(PAPER_ERROR_IN),
    .ACK_N_IN(ACK_N_IN), .BUSY_IN(BUSY_IN), .EPP_ENABLE_IN(epp_en),
    .STROBE_N_OUT(STROBE_N_OUT), .AUTOFEED_N_OUT(AUTOFEED_N_OUT), .INIT_N_OUT(INIT_N_OUT),
    .SEL_IN_N_OUT(SEL_IN_N_OUT), .ACK_IRQ_OUT(ACK_IRQ_OUT));
  epr_printer u_epr_printer (.clk_in(CLK_IN), .pd_drive_in(PD_OUT), .pd_oe_n_in(PD_OE_N_OUT),
    .periph_byte_in(pbyte), .levels_in(lv), .ack_req_in(ack_req), .pd_line_out(PD_IN),
    .fault_n_out(FAULT_N_IN), .select_out(SELECT_IN), .paper_error_out(PAPER_ERROR_IN),
    .ack_n_out(ACK_N_IN), .busy_out(BUSY_IN));

  initial forever #2 CLK_IN = ~CLK_IN;

  task automatic wrap_up;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : wrap_up

  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask : chk

  task automatic tmo(input int n);
    if (n >= 20) begin
      n_fail++;
      wrap_up;
    end
  endtask : tmo

  // Bus cycle plus reference model update
  task automatic bus(input logic w, input logic [15:0] ofs, input logic [7:0] d,
                     input string s = "", input logic a = 1'b0);
    logic [7:0] e;
    e = 8'h00;
    WR_IN <= w;
    RD_IN <= !w;
    AEN_IN <= a;
    ADDR_IN <= BASE + ofs;
    WDATA_IN <= d;
    if (w && !a) case (ofs)
      16'h0: if (m_mode < 3'h2) m_data = d;
      16'h2: m_ctrl = d[5:0];
      16'h400: if (m_mode == 3'h6 && q.size() < 16) q.push_back(d);
      16'h402: begin
        m_mode = d[7:5];
        m_srv = d[2];
        if (d[7:5] == 3'h0) q = {};
      end
      default: ;
    endcase
    if (!w && !a) case (ofs)
      16'h0: e = (m_mode == 3'h1 && m_ctrl[5]) ? pbyte : m_data;
      16'h1: e = {!BUSY_IN, ACK_N_IN, PAPER_ERROR_IN, SELECT_IN, FAULT_N_IN, 3'h0};
      16'h2: e = {2'h0, m_ctrl};
      16'h400: begin
        if (m_mode != 3'h7 && q.size() > 0) last = q.pop_front();
        e = (m_mode == 3'h7) ? 8'h10 : last;
      end
      16'h402: e = {m_mode, 2'h0, m_srv, q.size() == 16, q.size() == 0};
      default: ;
    endcase
    if (m_mode inside {3'h2, 3'h3, 3'h6} && (m_ctrl[5] ? q.size() >= 8 : q.size() <= 8))
      m_srv = 1'b1;
    @(posedge CLK_IN);
    WR_IN <= 1'b0;
    RD_IN <= 1'b0;
    AEN_IN <= 1'b0;
    #1;
    if (!w) chk(s, e, ofs == 16'h401 ? RDATA_OUT & 8'hBF : RDATA_OUT);
    @(posedge CLK_IN);
  endtask : bus

  initial begin
    #100000;
    n_fail++;
    wrap_up;
  end

  initial begin
    last = 8'h00;
    m_data = 8'h00;
    void'($urandom(32'h036BD301));
    repeat (4) @(posedge CLK_IN);
    RESET_N_IN <= 1'b1;
    repeat (3) @(posedge CLK_IN);
    bus(0, 16'h0, 8'h00, "data rst");
    bus(0, 16'h2, 8'h00, "ctrl rst");
    bus(0, 16'h402, 8'h00, "ext rst");
    for (int i = 0; i < 4; i++) begin
      lv <= 4'($urandom);
      pbyte <= 8'($urandom);
      @(posedge CLK_IN);
      bus(0, 16'h1, 8'h00, "status");
      bus(1, 16'h402, {i[0] ? 3'h1 : 3'h0, 5'h04});
      c = 8'($urandom);
      c[5] = i[1];
      bus(1, 16'h2, c);
      bus(1, 16'h0, 8'($urandom));
      bus(0, 16'h0, 8'h00, "data lines");
      bus(0, 16'h2, 8'h00, "ctrl");
      chk("pd drive", m_data, PD_OUT);
      chk("line outs", {3'h0, i[0] & c[5], ~c[3], c[2], ~c[1], ~c[0]},
          {3'h0, PD_OE_N_OUT, SEL_IN_N_OUT, INIT_N_OUT, AUTOFEED_N_OUT, STROBE_N_OUT});
    end
    bus(1, 16'h2, 8'h3F, "", 1'b1);
    bus(0, 16'h2, 8'h00, "ctrl aen");
    bus(0, 16'h2, 8'h00, "ctrl aen read", 1'b1);
    for (int j = 0; j < 2; j++) begin
      bus(1, 16'h2, j ? 8'h10 : 8'h00);
      ack_req <= 1'b1;
      @(posedge CLK_IN);
      ack_req <= 1'b0;
      for (k = 0; k < 20 && ACK_IRQ_OUT !== 1'b1; k++) @(posedge CLK_IN);
      chk("ack irq", j[7:0], {7'h0, k < 20});
    end
    lv <= 4'h1;
    bus(1, 16'h402, 8'h04);
    bus(1, 16'h2, 8'h00);
    for (int j = 2; j < 4; j++) begin
      c = 8'($urandom);
      bus(1, 16'h402, {j[2:0], 5'h04});
      bus(1, j == 2 ? 16'h400 : 16'h0, c);
      for (k = 0; k < 20 && STROBE_N_OUT !== 1'b0; k++) @(posedge CLK_IN);
      tmo(k);
      repeat (2) @(posedge CLK_IN);
      chk("fwd byte", c, PD_OUT);
      chk("addr tag", {7'h0, j == 2}, {7'h0, AUTOFEED_N_OUT});
      for (k = 2; k < 200 && STROBE_N_OUT === 1'b0; k++) @(posedge CLK_IN);
      chk("strobe cycles", 8'(`EPR_STROBE_CYC), 8'(k));
      bus(1, 16'h402, 8'h04);
    end
    bus(1, 16'h2, 8'h20);
    epp_en <= 1'b1;
    bus(1, 16'h402, 8'h84);
    chk("epp dir", 8'h01, {7'h0, PD_OE_N_OUT});
    epp_en <= 1'b0;
    @(posedge CLK_IN);
    chk("epp off dir", 8'h00, {7'h0, PD_OE_N_OUT});
    bus(1, 16'h402, 8'h64);
    ack_req <= 1'b1;
    @(posedge CLK_IN);
    ack_req <= 1'b0;
    q.push_back(pbyte);
    repeat (2) @(posedge CLK_IN);
    chk("host ack", 8'h01, {7'h0, AUTOFEED_N_OUT});
    repeat (6) @(posedge CLK_IN);
    bus(0, 16'h402, 8'h00, "ext rev");
    bus(0, 16'h400, 8'h00, "rev byte");
    bus(0, 16'h402, 8'h00, "ext rev empty");
    bus(1, 16'h402, 8'h04);
    bus(1, 16'h402, 8'hC0);
    for (int i = 0; i < 17; i++) begin
      bus(1, 16'h400, 8'($urandom));
      bus(0, 16'h402, 8'h00, "ext fill");
    end
    for (int i = 0; i < 17; i++) begin
      bus(0, 16'h400, 8'h00, "fifo read");
      bus(0, 16'h402, 8'h00, "ext drain");
    end
    bus(1, 16'h402, 8'h04);
    bus(1, 16'h402, 8'hE4);
    bus(0, 16'h400, 8'h00, "config a");
    bus(0, 16'h401, 8'h00, "config b");
    bus(1, 16'h400, 8'h55);
    bus(0, 16'h400, 8'h00, "config a ro");
    wrap_up;
  end
endmodule : ecp_parallel_port_registers_tb
`default_nettype wire

// [epr_consts.svh]
`ifndef EPR_CONSTS_SVH
`define EPR_CONSTS_SVH
`define EPR_OFS_DATA 16'h0000
`define EPR_OFS_STATUS 16'h0001
`define EPR_OFS_CTRL 16'h0002
`define EPR_OFS_FIFO 16'h0400
`define EPR_OFS_CFG_B 16'h0401
`define EPR_OFS_EXT 16'h0402
`define EPR_DATA_RST 8'h00
`define EPR_CTRL_RST 6'h00
`define EPR_EXT_RST 6'h01
`define EPR_CFG_A_VAL 8'h10
`define EPR_CTRL_STB 0
`define EPR_CTRL_AFD 1
`define EPR_CTRL_INIT 2
`define EPR_CTRL_SELI 3
`define EPR_CTRL_ACKEN 4
`define EPR_CTRL_DIR 5
`define EPR_EXT_MODE 5
`define EPR_EXT_ERREN 4
`define EPR_EXT_DMAEN 3
`define EPR_EXT_SRV 2
`define EPR_CLK_NS 4
`define EPR_STROBE_NS 500
`define EPR_STROBE_CYC ((`EPR_STROBE_NS + `EPR_CLK_NS - 1) / `EPR_CLK_NS)
`endif

// [epr_pkg.sv]
package epr_pkg;
  typedef enum logic [2:0] {
    EPR_SPP = 3'h0,
    EPR_BYTE = 3'h1,
    EPR_FIFO = 3'h2,
    EPR_ECP = 3'h3,
    EPR_EPP = 3'h4,
    EPR_RSVD = 3'h5,
    EPR_TEST = 3'h6,
    EPR_CFG = 3'h7
  } epr_mode_t;
  typedef enum logic [1:0] {
    EPR_IDLE,
    EPR_STROBE,
    EPR_WAIT,
    EPR_HOLD
  } epr_link_t;
endpackage : epr_pkg

// [epr_port.sv]
`timescale 1ns/1ns
`default_nettype none
`include "epr_consts.svh"
module epr_port #(
  parameter int DEPTH = 16,
  parameter int WR_THRESH = 8,
  parameter int RD_THRESH = 8
) (
  input wire logic CLK_IN,
  input wire logic RESET_N_IN,
  input wire logic [15:0] BASE_ADDR_IN,
  input wire logic [15:0] ADDR_IN,
  input wire logic AEN_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  input wire logic [7:0] WDATA_IN,
  output logic [7:0] RDATA_OUT,
  input wire logic [7:0] PD_IN,
  output logic [7:0] PD_OUT,
  output logic PD_OE_N_OUT,
  input wire logic FAULT_N_IN,
  input wire logic SELECT_IN,
  input wire logic PAPER_ERROR_IN,
  input wire logic ACK_N_IN,
  input wire logic BUSY_IN,
  input wire logic EPP_ENABLE_IN,
  output logic STROBE_N_OUT,
  output logic AUTOFEED_N_OUT,
  output logic INIT_N_OUT,
  output logic SEL_IN_N_OUT,
  output logic ACK_IRQ_OUT
);
  import epr_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam int STB_CYC = `EPR_STROBE_CYC;

  if (DEPTH < 2 || (1 << AW) != DEPTH || STB_CYC > 255 ||
      WR_THRESH > DEPTH || RD_THRESH > DEPTH || WR_THRESH < 1 || RD_THRESH < 1) begin : g_chk
    $error("epr_port: unsupported parameter values");
  end

  // ****************************************
  // Reset release
  // ****************************************
  logic rst_meta_q;
  logic rst_n;
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  // ****************************************
  // Decode
  // ****************************************
  logic [2:0] mode_q;
  logic [5:0] ctrl_q;
  logic [7:0] data_q;
  logic err_en_q;
  logic dma_en_q;
  logic service_q;
  logic full;
  logic empty;
  epr_link_t st_q;

  wire logic [15:0] offset = ADDR_IN - BASE_ADDR_IN;
  wire logic sel = ~AEN_IN;
  wire logic hit_data = sel && offset == `EPR_OFS_DATA;
  wire logic hit_status = sel && offset == `EPR_OFS_STATUS;
  wire logic hit_ctrl = sel && offset == `EPR_OFS_CTRL;
  wire logic hit_fifo = sel && offset == `EPR_OFS_FIFO;
  wire logic hit_cfgb = sel && offset == `EPR_OFS_CFG_B;
  wire logic hit_ext = sel && offset == `EPR_OFS_EXT;

  wire logic m_spp = mode_q == EPR_SPP;
  wire logic m_byte = mode_q == EPR_BYTE;
  wire logic m_fifo = mode_q == EPR_FIFO;
  wire logic m_ecp = mode_q == EPR_ECP;
  wire logic m_epp = mode_q == EPR_EPP && EPP_ENABLE_IN;
  wire logic m_test = mode_q == EPR_TEST;
  wire logic m_cfg = mode_q == EPR_CFG;
  wire logic m_latch = m_spp || m_byte || m_epp;
  wire logic dir_in = ctrl_q[`EPR_CTRL_DIR] && !m_spp && !m_fifo && (mode_q != EPR_EPP || m_epp);
  wire logic auto_fwd = (m_fifo || m_ecp) && !dir_in;
  wire logic auto_rev = m_ecp && dir_in;

  // Mode selects which register answers at the data and FIFO offsets
  wire logic wr_data = WR_IN && hit_data && m_latch;
  wire logic wr_afifo = WR_IN && hit_data && m_ecp && !dir_in;
  wire logic wr_fifo = WR_IN && hit_fifo && (auto_fwd || m_test);
  wire logic wr_ctrl = WR_IN && hit_ctrl;
  wire logic wr_ext = WR_IN && hit_ext;
  wire logic rd_fifo = RD_IN && hit_fifo && (auto_rev || m_test);

  // ****************************************
  // Shared FIFO, tag in bit 8
  // ****************************************
  logic [8:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [CW-1:0] cnt_q;
  logic [7:0] last_q;
  logic push_rx;
  logic pop_tx;

  wire logic push_host = (wr_afifo || wr_fifo) && !full;
  wire logic pop_host = rd_fifo && !empty;
  wire logic push = push_host || push_rx;
  wire logic pop = pop_host || pop_tx;
  wire logic [8:0] push_word = push_rx ? {1'b0, PD_IN} : {wr_afifo, WDATA_IN};
  wire logic [8:0] head = mem_q[rp_q];
  wire logic flush = m_spp;
  assign full = cnt_q == CW'(DEPTH);
  assign empty = cnt_q == '0;
  wire logic [CW-1:0] free = CW'(DEPTH) - cnt_q;

  for (genvar i = 0; i < DEPTH; i++) begin : g_mem
    always_ff @(posedge CLK_IN) begin
      if (push && wp_q == AW'(i)) begin
        mem_q[i] <= push_word;
      end
    end
  end

  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else if (flush) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      wp_q <= wp_q + AW'(push);
      rp_q <= rp_q + AW'(pop);
      cnt_q <= cnt_q + CW'(push) - CW'(pop);
    end
  end

  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      last_q <= 8'h00;
    end else if (pop_host) begin
      last_q <= head[7:0];
    end
  end

  // ****************************************
  // Software registers
  // ****************************************
  wire logic thr_hit = dir_in ? cnt_q >= CW'(RD_THRESH) : free >= CW'(WR_THRESH);
  wire logic srv_set = (m_fifo || m_ecp || m_test) && !dma_en_q && thr_hit;

  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      data_q <= `EPR_DATA_RST;
      ctrl_q <= `EPR_CTRL_RST;
      {mode_q, err_en_q, dma_en_q, service_q} <= `EPR_EXT_RST;
    end else begin
      if (wr_data) begin
        data_q <= WDATA_IN;
      end
      if (wr_ctrl) begin
        ctrl_q <= WDATA_IN[5:0];
      end
      if (wr_ext) begin
        mode_q <= WDATA_IN[7:`EPR_EXT_MODE];
        err_en_q <= WDATA_IN[`EPR_EXT_ERREN];
        dma_en_q <= WDATA_IN[`EPR_EXT_DMAEN];
      end
      // Set beats a clearing write in the same cycle
      service_q <= srv_set || (wr_ext ? WDATA_IN[`EPR_EXT_SRV] : service_q);
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  wire logic [7:0] status_rd = {~BUSY_IN, ACK_N_IN, PAPER_ERROR_IN, SELECT_IN, FAULT_N_IN, 3'h0};
  wire logic [7:0] ctrl_rd = {2'h0, ctrl_q};
  wire logic [7:0] ext_rd = {mode_q, err_en_q, dma_en_q, service_q, full, empty};
  wire logic [7:0] fifo_rd = empty ? last_q : head[7:0];
  logic ack_irq_q;
  logic [7:0] rd_mux;

  always_comb begin
    rd_mux = 8'h00;
    if (hit_data && m_latch) begin
      rd_mux = PD_IN;
    end else if (hit_status) begin
      rd_mux = status_rd;
    end else if (hit_ctrl) begin
      rd_mux = ctrl_rd;
    end else if (hit_fifo && m_cfg) begin
      rd_mux = `EPR_CFG_A_VAL;
    end else if (hit_fifo && (auto_rev || m_test)) begin
      rd_mux = fifo_rd;
    end else if (hit_cfgb && m_cfg) begin
      rd_mux = {1'b0, ack_irq_q, 6'h00};
    end else if (hit_ext) begin
      rd_mux = ext_rd;
    end
  end

  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      RDATA_OUT <= 8'h00;
    end else begin
      RDATA_OUT <= RD_IN ? rd_mux : 8'h00;
    end
  end

  // ****************************************
  // Acknowledge interrupt
  // ****************************************
  logic ack_prev_q;
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      ack_prev_q <= 1'b1;
      ack_irq_q <= 1'b0;
    end else begin
      ack_prev_q <= ACK_N_IN;
      ack_irq_q <= ctrl_q[`EPR_CTRL_ACKEN] && ACK_N_IN && !ack_prev_q;
    end
  end
  assign ACK_IRQ_OUT = ack_irq_q;

  // ****************************************
  // Link handshake
  // ****************************************
  logic [7:0] tmr_q;
  logic [8:0] tx_q;
  epr_link_t st_d;

  always_comb begin
    st_d = st_q;
    pop_tx = 1'b0;
    push_rx = 1'b0;
    unique case (st_q)
      EPR_IDLE: begin
        if (auto_fwd && !empty && !BUSY_IN) begin
          pop_tx = 1'b1;
          st_d = EPR_STROBE;
        end else if (auto_rev && !ACK_N_IN && !full) begin
          push_rx = 1'b1;
          st_d = EPR_HOLD;
        end
      end
      EPR_STROBE: begin
        if (!auto_fwd) begin
          st_d = EPR_IDLE;
        end else if (tmr_q == 8'h01) begin
          st_d = EPR_WAIT;
        end
      end
      EPR_WAIT: begin
        if (!auto_fwd || !BUSY_IN) begin
          st_d = EPR_IDLE;
        end
      end
      EPR_HOLD: begin
        if (!auto_rev || ACK_N_IN) begin
          st_d = EPR_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= EPR_IDLE;
      tmr_q <= 8'h00;
      tx_q <= 9'h000;
    end else begin
      st_q <= st_d;
      tmr_q <= pop_tx ? 8'(STB_CYC) : tmr_q - 8'(tmr_q != 8'h00);
      if (pop_tx) begin
        tx_q <= head;
      end
    end
  end

  // ****************************************
  // Pin drive
  // ****************************************
  // Test mode shows the FIFO head on the lines, no handshake
  wire logic [7:0] pd_mux = auto_fwd ? tx_q[7:0] : (m_test ? head[7:0] : data_q);
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      PD_OUT <= 8'h00;
    end else begin
      PD_OUT <= pd_mux;
    end
  end

  assign PD_OE_N_OUT = dir_in;
  assign STROBE_N_OUT = auto_fwd ? st_q != EPR_STROBE : !ctrl_q[`EPR_CTRL_STB];
  assign AUTOFEED_N_OUT = auto_fwd ? !tx_q[8] :
                          auto_rev ? st_q == EPR_HOLD : !ctrl_q[`EPR_CTRL_AFD];
  assign INIT_N_OUT = ctrl_q[`EPR_CTRL_INIT];
  assign SEL_IN_N_OUT = !ctrl_q[`EPR_CTRL_SELI];

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!rst_n);

  a_status_low_zero: assert property (RD_IN && hit_status |=> RDATA_OUT[2:0] == 3'h0)
    else $error("status low bits not zero");
  a_status_busy_inv: assert property (RD_IN && hit_status |=> RDATA_OUT[7] == !$past(BUSY_IN))
    else $error("busy bit not inverted");
  a_status_ack_live: assert property (RD_IN && hit_status |=> RDATA_OUT[6] == $past(ACK_N_IN))
    else $error("ack bit wrong");
  a_ctrl_top_zero: assert property (RD_IN && hit_ctrl |=> RDATA_OUT[7:6] == 2'h0)
    else $error("control top bits not zero");
  a_init_direct: assert property (wr_ctrl |=> INIT_N_OUT == $past(WDATA_IN[2]))
    else $error("initialize polarity wrong");
  a_strobe_inv: assert property (wr_ctrl && !auto_fwd ##1 !auto_fwd |-> STROBE_N_OUT == !$past(WDATA_IN[0]))
    else $error("strobe not inverted");
  a_ack_irq_edge: assert property (!ACK_N_IN ##1 ACK_N_IN && ctrl_q[4] |=> ACK_IRQ_OUT)
    else $error("missed ack interrupt");
  a_full_drop: assert property (m_test && WR_IN && hit_fifo && full |=> cnt_q == $past(cnt_q))
    else $error("write to full fifo stored");
  a_empty_reread: assert property (m_test && RD_IN && hit_fifo && empty |=> RDATA_OUT == $past(last_q) && $stable(rp_q))
    else $error("empty read not repeated");
  a_cfga_value: assert property (m_cfg && RD_IN && hit_fifo |=> RDATA_OUT == `EPR_CFG_A_VAL)
    else $error("config A value wrong");
  a_dir_forced: assert property (m_spp || m_fifo |-> !PD_OE_N_OUT)
    else $error("direction not forced out");
  a_aen_block: assert property (AEN_IN && WR_IN |=> $stable(ctrl_q) && $stable(mode_q))
    else $error("qualified access hit register");
  a_service_wr: assert property (m_test && !dma_en_q && !dir_in && free >= CW'(WR_THRESH)
    |=> service_q)
    else $error("service flag not set on free space");
  a_service_rd: assert property (m_test && !dma_en_q && dir_in && cnt_q >= CW'(RD_THRESH)
    |=> service_q)
    else $error("service flag not set on fill level");
  a_pd_follows: assert property (m_latch |=> PD_OUT == $past(data_q))
    else $error("data lines not driven from latch");
  a_data_read: assert property (RD_IN && hit_data && m_latch |=> RDATA_OUT == $past(PD_IN))
    else $error("data read not from lines");
  a_autofeed_inv: assert property (wr_ctrl && !auto_fwd && !auto_rev ##1 !auto_fwd && !auto_rev
    |-> AUTOFEED_N_OUT == !$past(WDATA_IN[1]))
    else $error("autofeed not inverted");
  a_cfgb_top: assert property (m_cfg && RD_IN && hit_cfgb |=> !RDATA_OUT[7])
    else $error("config B top bit set");
  a_ext_mode_rd: assert property (RD_IN && hit_ext |=> RDATA_OUT[7:5] == $past(mode_q))
    else $error("mode field read wrong");
  a_fifo_flags: assert property (RD_IN && hit_ext |=>
    RDATA_OUT[1:0] == {$past(cnt_q) == CW'(DEPTH), $past(cnt_q) == CW'(0)})
    else $error("full or empty flag wrong");
  a_aen_no_read: assert property (AEN_IN && RD_IN |=> RDATA_OUT == 8'h00)
    else $error("qualified read returned data");
  a_ack_irq_pulse: assert property (ACK_IRQ_OUT |=> !ACK_IRQ_OUT)
    else $error("ack interrupt longer than one cycle");
  a_rx_hold: assert property (push_rx ##1 auto_rev |-> AUTOFEED_N_OUT)
    else $error("host ack not raised after capture");
  a_fwd_tag: assert property (pop_tx ##1 auto_fwd |-> AUTOFEED_N_OUT == !$past(head[8]))
    else $error("address tag not shown");
  a_test_no_link: assert property (m_test ##1 m_test |-> st_q == EPR_IDLE)
    else $error("handshake active in test mode");

  c_test_full: cover property (m_test && full ##[1:40] m_test && empty);
  c_ecp_send: cover property (m_ecp && st_q == EPR_STROBE ##[1:300] st_q == EPR_IDLE);
  c_ack_irq: cover property (ACK_IRQ_OUT);
  c_rev_capture: cover property (auto_rev && push_rx);
  c_service_set: cover property (m_test && srv_set && !service_q);
endmodule : epr_port
`default_nettype wire

// [epr_printer.sv]
`timescale 1ns/1ns
`default_nettype none
// ************
// Peripheral
// ************
module epr_printer (
  input wire logic clk_in,
  input wire logic [7:0] pd_drive_in,
  input wire logic pd_oe_n_in,
  input wire logic [7:0] periph_byte_in,
  input wire logic [3:0] levels_in,
  input wire logic ack_req_in,
  output logic [7:0] pd_line_out,
  output logic fault_n_out,
  output logic select_out,
  output logic paper_error_out,
  output logic ack_n_out,
  output logic busy_out
);
  logic [1:0] ack_cnt_q = 2'h0;
  // Host owns the lines unless turned round
  assign pd_line_out = pd_oe_n_in ? periph_byte_in : pd_drive_in;
  assign {busy_out, paper_error_out, select_out, fault_n_out} = levels_in;
  // Ack held low three cycles, then released high
  always_ff @(posedge clk_in) begin
    if (ack_req_in) ack_cnt_q <= 2'h3;
    else if (ack_cnt_q != 2'h0) ack_cnt_q <= ack_cnt_q - 2'h1;
  end
  assign ack_n_out = (ack_cnt_q == 2'h0);
endmodule : epr_printer
`default_nettype wire
